// ==== pkg/css_pkg.sv ====
/*
  Package for the coprocessor store execution unit: store widths, opcode
  layout, protection and translation lookup answers, and carrier structs.
  Assumes a 32-bit byte-addressed data memory port, written in aligned words with byte enables.
*/
package css_pkg;

  localparam int unsigned GPR_COUNT   = 32;
  localparam int unsigned GPR_IDX_W   = 5;
  localparam logic [4:0]  GPR_ZERO    = 5'h00;
  localparam logic [31:0] ADDR_ZERO   = 32'h00000000;
  localparam logic [31:0] WORD_ALIGN  = 32'hfffffffc;
  localparam logic [31:0] BEAT_STEP   = 32'h00000004;
  localparam logic [1:0]  BEATS_ONE   = 2'h0;
  localparam logic [1:0]  BEATS_TWO   = 2'h1;
  localparam logic [1:0]  BEATS_FOUR  = 2'h3;
  localparam logic [3:0]  BE_BYTE     = 4'h1;
  localparam logic [3:0]  BE_HALF     = 4'h3;
  localparam logic [3:0]  BE_WORD     = 4'hf;
  localparam logic [31:0] MASK_BYTE   = 32'h000000ff;
  localparam logic [31:0] MASK_HALF   = 32'h0000ffff;

  typedef enum logic [2:0] {
    CSS_SZ_BYTE,
    CSS_SZ_HALF,
    CSS_SZ_WORD,
    CSS_SZ_DOUBLE,
    CSS_SZ_QUAD
  } css_size_t;

  // One store instruction issued by the pipeline.
  typedef struct packed {
    css_size_t             size;
    logic                  update;
    logic [GPR_IDX_W-1:0]  baseGpr;
    logic [GPR_IDX_W-1:0]  indexGpr;
    logic [GPR_IDX_W-1:0]  coprocessorSourceRegField;
    logic                  reservedNonZero;
  } css_instr_t;

  // Machine state for the translation and protection check.
  typedef struct packed {
    logic relocEnable;
    logic userMode;
    logic tlbHit;
    logic zoneNoAccess;
    logic zoneReadOnly;
  } css_mmu_t;

  // One word write toward memory.
  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0]  byteEn;
  } css_mem_t;

  // Completion report.
  typedef struct packed {
    logic done;
    logic dataStorageExc;
    logic tlbMissExc;
    logic undefinedForm;
  } css_status_t;

endpackage

// ==== verilog/css_gpr_file.sv ====
/*
  General register file with two registered read ports and one write port.
  Assumes a single clock and synchronous reads returning the next cycle.
*/
`timescale 1ns/10ps
module css_gpr_file (
  // Clock and reset.
  input  wire logic                           core_clk,
  input  wire logic                           sys_rst,
  // Read ports.
  input  wire logic [css_pkg::GPR_IDX_W-1:0]  rdAddrA,
  input  wire logic [css_pkg::GPR_IDX_W-1:0]  rdAddrB,
  output logic      [31:0]                    rdDataA,
  output logic      [31:0]                    rdDataB,
  // Write port.
  input  wire logic                           wrEn,
  input  wire logic [css_pkg::GPR_IDX_W-1:0]  wrAddr,
  input  wire logic [31:0]                    wrData
);
  import css_pkg::*;

  logic [31:0] mem [GPR_COUNT];

  genvar g;
  generate
    for (g = 0; g < GPR_COUNT; g++) begin : gReg
      always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
          mem[g] <= ADDR_ZERO;
        end else if (wrEn && wrAddr == GPR_IDX_W'(g)) begin
          mem[g] <= wrData;
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdDataA <= ADDR_ZERO;
      rdDataB <= ADDR_ZERO;
    end else begin
      rdDataA <= mem[rdAddrA];
      rdDataB <= mem[rdAddrB];
    end
  end

endmodule

// ==== verilog/css_store_unit.sv ====
/*
  Store execution unit for stores whose data comes from a fabric coprocessor.
  Holds the general registers, forms the effective address, checks
  translation and zone protection, fetches one word per beat from the
  coprocessor and writes it to memory, then updates the base register.
  Assumes the coprocessor answers each fetch with a valid pulse and that the
  memory port takes a write in the cycle it is offered.
*/
`timescale 1ns/10ps

module css_store_unit (
  // Clock and reset.
  input  wire logic                           core_clk,
  input  wire logic                           sys_rst,
  // Instruction issue.
  input  wire logic                           instrValid,
  output logic                                instrReady,
  input  wire css_pkg::css_instr_t            instr,
  input  wire css_pkg::css_mmu_t              mmu,
  // Coprocessor data fetch.
  output logic                                cpFetchReq,
  output logic [css_pkg::GPR_IDX_W-1:0]       cpSourceReg,
  output logic [1:0]                          cpBeat,
  input  wire logic                           cpDataValid,
  input  wire logic [31:0]                    cpData,
  // Memory write port.
  output css_pkg::css_mem_t                   memWr,
  output logic [31:0]                         memCheckAddr,
  // Completion.
  output css_pkg::css_status_t                status,
  // General register loading by the pipeline.
  input  wire logic                           gprLoadEn,
  input  wire logic [css_pkg::GPR_IDX_W-1:0]  gprLoadAddr,
  input  wire logic [31:0]                    gprLoadData
);
  import css_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_READ,
    ST_CHECK,
    ST_FETCH,
    ST_WRITE,
    ST_DONE
  } css_state_t;

  typedef struct packed {
    css_state_t  state;
    css_instr_t  ins;
    logic [31:0] ea;
    logic [1:0]  beat;
    logic [1:0]  lastBeat;
    logic [31:0] word;
    css_mem_t    mem;
    css_status_t stat;
    logic        wbEn;
  } css_regs_t;

  css_regs_t   r;
  css_regs_t   nxt;
  logic [31:0] baseVal;
  logic [31:0] indexVal;
  logic        gprWrEn;
  logic        wbNow;
  logic [31:0] sum;
  logic        storageFault;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [1:0] last_beat(input css_size_t s);
    case (s)
      CSS_SZ_DOUBLE: last_beat = BEATS_TWO;
      CSS_SZ_QUAD:   last_beat = BEATS_FOUR;
      default:       last_beat = BEATS_ONE;
    endcase
  endfunction

  function automatic logic [3:0] byte_en(input css_size_t s);
    case (s)
      CSS_SZ_BYTE: byte_en = BE_BYTE;
      CSS_SZ_HALF: byte_en = BE_HALF;
      default:     byte_en = BE_WORD;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  css_gpr_file uGpr (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .rdAddrA  (r.ins.baseGpr),
    .rdAddrB  (r.ins.indexGpr),
    .rdDataA  (baseVal),
    .rdDataB  (indexVal),
    .wrEn     (gprWrEn),
    .wrAddr   (wbNow ? r.ins.baseGpr : gprLoadAddr),
    .wrData   (wbNow ? r.ea : gprLoadData)
  );

  // Write-back of the base register takes priority over pipeline loads.
  // The port is steered only in the completion cycle, so a load that lands
  // while an update store is still busy keeps its own address and data.
  assign wbNow   = (r.state == ST_DONE) && r.wbEn;
  assign gprWrEn = wbNow || gprLoadEn;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    sum = ADDR_ZERO;
    storageFault = 1'b0;
    nxt = r;
    nxt.mem.valid = 1'b0;
    nxt.stat.done = 1'b0;
    case (r.state)
      ST_IDLE: begin
        if (instrValid) begin
          nxt.ins = instr;
          nxt.beat = BEATS_ONE;
          nxt.lastBeat = last_beat(instr.size);
          nxt.state = ST_READ;
        end
      end
      ST_READ: begin
        nxt.state = ST_CHECK;
      end
      ST_CHECK: begin
        // Update forms never substitute zero; with base field zero the
        // register's own value is used, a bounded undefined result.
        if (!r.ins.update && r.ins.baseGpr == GPR_ZERO) begin
          sum = ADDR_ZERO + indexVal;
        end else begin
          sum = baseVal + indexVal;
        end
        nxt.ea = sum & WORD_ALIGN;
        storageFault = (mmu.zoneNoAccess && mmu.userMode)
                       || mmu.zoneReadOnly;
        nxt.stat.dataStorageExc = mmu.relocEnable && storageFault;
        nxt.stat.tlbMissExc = mmu.relocEnable && !mmu.tlbHit;
        // Nonzero reserved bits only raise undefinedForm; the store proceeds.
        nxt.stat.undefinedForm = r.ins.reservedNonZero
                                 || (r.ins.update && r.ins.baseGpr == GPR_ZERO);
        if (nxt.stat.dataStorageExc || nxt.stat.tlbMissExc) begin
          nxt.wbEn = 1'b0;
          nxt.state = ST_DONE;
        end else begin
          nxt.wbEn = r.ins.update;
          nxt.state = ST_FETCH;
        end
      end
      ST_FETCH: begin
        if (cpDataValid) begin
          nxt.word = cpData;
          nxt.state = ST_WRITE;
        end
      end
      ST_WRITE: begin
        nxt.mem.valid = 1'b1;
        nxt.mem.addr = r.ea + BEAT_STEP * 32'(r.beat);
        nxt.mem.byteEn = byte_en(r.ins.size);
        case (r.ins.size)
          CSS_SZ_BYTE: nxt.mem.data = r.word & MASK_BYTE;
          CSS_SZ_HALF: nxt.mem.data = r.word & MASK_HALF;
          default:     nxt.mem.data = r.word;
        endcase
        if (r.beat == r.lastBeat) begin
          nxt.state = ST_DONE;
        end else begin
          nxt.beat = r.beat + 2'h1;
          nxt.state = ST_FETCH;
        end
      end
      ST_DONE: begin
        nxt.stat.done = 1'b1;
        nxt.wbEn = 1'b0;
        nxt.state = ST_IDLE;
      end
      default: begin
        nxt.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      r <= '0;
    end else begin
      r <= nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign instrReady   = (r.state == ST_IDLE);
  assign cpFetchReq   = (r.state == ST_FETCH);
  assign cpSourceReg  = r.ins.coprocessorSourceRegField;
  assign cpBeat       = r.beat;
  assign memWr        = r.mem;
  assign memCheckAddr = r.ea;
  assign status       = r.stat;

endmodule

// ==== verification/css_cp_model.sv ====
/*
  Coprocessor model: answers each fetch with one word after cpWait idle cycles.
  Assumes the store unit holds cpFetchReq until it takes the word.
*/
`timescale 1ns/10ps
module css_cp_model (
  // Fetch request.
  input  wire logic        core_clk,
  input  wire logic        cpFetchReq,
  input  wire logic [4:0]  cpSourceReg,
  input  wire logic [1:0]  cpBeat,
  input  wire logic [1:0]  cpWait,
  // Data answer.
  output logic             cpDataValid,
  output logic [31:0]      cpData
);
  logic [2:0] cnt = 3'h0;
  initial {cpDataValid, cpData} = 33'h0;
  // Each beat of a wide source gives its own word; idle data keeps toggling.
  // The beat number rides in the word so order can be judged.
  always @(posedge core_clk) begin
    #2;
    {cpDataValid, cpData} = {1'b0, ~cpData};
    cnt = cpFetchReq ? cnt + 3'h1 : 3'h0;
    if (cpFetchReq && cnt > {1'b0, cpWait}) begin
      {cpDataValid, cpData} = {1'b1, cpBeat, 1'b1, cpSourceReg, 24'h5a3c96};
      cnt = 3'h0;
    end
  end
endmodule

// ==== verification/css_store_unit_monitor.sv ====
/*
  Port checker for the store unit.
  Assumes mmu is held steady from issue to completion.
*/
`timescale 1ns/10ps
module css_store_unit_monitor (
  // Clock and reset.
  input wire logic                 core_clk,
  input wire logic                 sys_rst,
  // Issue and fetch.
  input wire logic                 instrValid,
  input wire logic                 instrReady,
  input wire css_pkg::css_instr_t  instr,
  input wire css_pkg::css_mmu_t    mmu,
  input wire logic                 cpFetchReq,
  input wire logic                 cpDataValid,
  input wire logic [31:0]          cpData,
  // Results.
  input wire css_pkg::css_mem_t    memWr,
  input wire logic [31:0]          memCheckAddr,
  input wire css_pkg::css_status_t status
);
  import css_pkg::*;
  logic [2:0] nWr_r;
  logic [2:0] nWr;
  logic [2:0] nExp;
  css_instr_t ins_r;
  css_mmu_t   mm_r;
  assign nWr  = nWr_r + {2'h0, memWr.valid};
  assign nExp = ins_r.size == CSS_SZ_QUAD ? 3'h4 : ins_r.size == CSS_SZ_DOUBLE ? 3'h2 : 3'h1;
  // Captures each issued store and counts its memory writes.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      {nWr_r, ins_r, mm_r} <= '0;
    end else if (instrValid && instrReady) begin
      {nWr_r, ins_r, mm_r} <= {3'h0, instr, mmu};
    end else begin
      nWr_r <= nWr;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  a_fetch_data:
    assert property (cpFetchReq && cpDataValid |-> ##2 memWr.valid &&
      ((memWr.data ^ $past(cpData, 2)) & MASK_BYTE) == 32'h0) else $error("bad store data");
  a_beat_addr:
    assert property (memWr.valid |-> memWr.addr == memCheckAddr + {27'h0, nWr_r, 2'h0}
      && memCheckAddr[1:0] == 2'h0) else $error("bad beat address");
  a_beat_count:
    assert property (status.done && !status.dataStorageExc && !status.tlbMissExc |->
      nWr == nExp) else $error("bad beat count");
  a_fault_quiet:
    assert property (status.done && (status.dataStorageExc || status.tlbMissExc) |->
      nWr == 3'h0) else $error("write on faulting store");
  a_miss_flag:
    assert property (status.done |-> status.tlbMissExc == (mm_r.relocEnable &&
      !mm_r.tlbHit)) else $error("bad miss flag");
  a_zone_flag:
    assert property (status.done |-> status.dataStorageExc ==
      (mm_r.relocEnable && ((mm_r.userMode && mm_r.zoneNoAccess) || mm_r.zoneReadOnly)))
      else $error("bad zone flag");
  a_undef_flag:
    assert property (status.done |-> status.undefinedForm == (ins_r.reservedNonZero ||
      (ins_r.update && ins_r.baseGpr == GPR_ZERO))) else $error("bad undefined flag");
  a_done_bound:
    assert property (instrValid && instrReady |-> ##[4:60] status.done)
      else $error("store never completed");
  c_quad: cover property (status.done && ins_r.size == CSS_SZ_QUAD);
  c_fault: cover property (status.done && status.dataStorageExc);
  c_undef: cover property (status.done && status.undefinedForm);
endmodule
bind css_store_unit css_store_unit_monitor i_mon (.core_clk(core_clk), .sys_rst(sys_rst),
  .instrValid(instrValid), .instrReady(instrReady), .instr(instr), .mmu(mmu),
  .cpFetchReq(cpFetchReq), .cpDataValid(cpDataValid), .cpData(cpData), .memWr(memWr),
  .memCheckAddr(memCheckAddr), .status(status));

// ==== verification/coprocessor_store_execution_test.sv ====
/*
  Bench for the coprocessor store unit with a coprocessor model.
  Assumes one store at a time, issued only while the unit is idle.
*/
`timescale 1ns/10ps
module coprocessor_store_execution_test;
  import css_pkg::*;
  logic        core_clk, sys_rst, instrValid, instrReady, cpFetchReq, cpDataValid, gprLoadEn;
  logic [1:0]  cpBeat, cpWait;
  logic [4:0]  cpSourceReg, gprLoadAddr;
  logic [31:0] cpData, memCheckAddr, gprLoadData;
  logic [31:0] gpr [32] = '{default: 32'h0};
  css_instr_t  instr;
  css_mmu_t    mmu;
  css_mem_t    memWr, wq[$];
  css_status_t status;
  int          n_mismatch = 0, comparisons = 0;
  css_store_unit i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .instrValid(instrValid),
    .instrReady(instrReady), .instr(instr), .mmu(mmu), .cpFetchReq(cpFetchReq),
    .cpSourceReg(cpSourceReg), .cpBeat(cpBeat), .cpDataValid(cpDataValid), .cpData(cpData),
    .memWr(memWr), .memCheckAddr(memCheckAddr), .status(status), .gprLoadEn(gprLoadEn),
    .gprLoadAddr(gprLoadAddr), .gprLoadData(gprLoadData));
  css_cp_model i_cp (.core_clk(core_clk), .cpFetchReq(cpFetchReq), .cpSourceReg(cpSourceReg),
    .cpBeat(cpBeat), .cpWait(cpWait), .cpDataValid(cpDataValid), .cpData(cpData));
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    #1;
    if (memWr.valid === 1'b1) wq.push_back(memWr);
  end
  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic setGpr(input logic [4:0] a, input logic [31:0] d);
    @(posedge core_clk);
    #2;
    {gprLoadEn, gprLoadAddr, gprLoadData, gpr[a]} = {1'b1, a, d, d};
    @(posedge core_clk);
    #2;
    gprLoadEn = 1'b0;
  endtask
  // Issues one store and checks flags, beats and lanes against values worked out here.
  task automatic store(input css_size_t sz, input logic up, input logic [4:0] b, x, m,
                       input logic rsv);
    logic [31:0] ea, msk;
    logic [3:0]  be;
    logic        fs, fm, rdy;
    int          k, nb;
    ea = (((b == GPR_ZERO && !up) ? ADDR_ZERO : gpr[b]) + gpr[x]) & WORD_ALIGN;
    msk = sz == CSS_SZ_BYTE ? MASK_BYTE : sz == CSS_SZ_HALF ? MASK_HALF : 32'hffffffff;
    be = sz == CSS_SZ_BYTE ? BE_BYTE : sz == CSS_SZ_HALF ? BE_HALF : BE_WORD;
    fm = m[4] & !m[2];
    fs = m[4] & (m[3] & m[1] | m[0]);
    nb = fs | fm ? 0 : sz == CSS_SZ_QUAD ? 4 : sz == CSS_SZ_DOUBLE ? 2 : 1;
    wq.delete();
    @(posedge core_clk);
    #2;
    {instrValid, instr, mmu} = {1'b1, sz, up, b, x, 5'h0b, rsv, m};
    @(posedge core_clk);
    #2;
    instrValid = 1'b0;
    rdy = instrReady;
    for (k = 0; k < 60 && status.done !== 1'b1; k++) @(posedge core_clk) #1;
    #2;
    chk({status, rdy, 32'(wq.size())},
        {1'b1, fs, fm, rsv | up & b == GPR_ZERO, 1'b0, 32'(nb)});
    foreach (wq[i]) begin
      chk({wq[i].byteEn, wq[i].addr, wq[i].data & msk},
          {be, ea + 32'(4 * i), {2'(i), 1'b1, 5'h0b, 24'h5a3c96} & msk});
    end
    if (up && !(fs | fm)) gpr[b] = ea;
  endtask
  task automatic t_sizes();
    setGpr(5'h00, 32'h00000400);
    setGpr(5'h01, 32'h00001000);
    setGpr(5'h02, 32'h00000010);
    setGpr(5'h04, 32'h00000013);
    for (int s = 0; s < 5; s++)
      store(css_size_t'(s), 1'b0, 5'h01, 5'h02, 5'h14, 1'b0);
    store(CSS_SZ_WORD, 1'b0, 5'h00, 5'h02, 5'h00, 1'b0);
    $display("sizes test done");
  endtask
  task automatic t_update();
    setGpr(5'h03, 32'h00002000);
    store(CSS_SZ_WORD, 1'b1, 5'h03, 5'h02, 5'h14, 1'b0);
    store(CSS_SZ_DOUBLE, 1'b1, 5'h03, 5'h02, 5'h14, 1'b0);
    cpWait = 2'h3;
    store(CSS_SZ_QUAD, 1'b1, 5'h03, 5'h04, 5'h14, 1'b0);
    cpWait = 2'h0;
    store(CSS_SZ_WORD, 1'b0, 5'h03, 5'h02, 5'h00, 1'b0);
    $display("update test done");
  endtask
  task automatic t_faults();
    logic [4:0] codes [7] = '{5'h10, 5'h1e, 5'h16, 5'h15, 5'h1d, 5'h1b, 5'h0b};
    foreach (codes[i])
      store(CSS_SZ_HALF, 1'b1, 5'h03, 5'h02, codes[i],
            1'b0);
    $display("fault test done");
  endtask
  task automatic t_invalid();
    store(CSS_SZ_WORD, 1'b0, 5'h01, 5'h02, 5'h14, 1'b1);
    store(CSS_SZ_BYTE, 1'b1, 5'h00, 5'h02, 5'h14, 1'b0);
    $display("invalid form test done");
  endtask
  initial begin
    #150000;
    n_mismatch++;
    final_report();
  end
  initial begin
    sys_rst = 1'b1;
    {instrValid, gprLoadEn, gprLoadAddr, gprLoadData, instr, mmu, cpWait} = 66'h0;
    repeat (3) @(posedge core_clk);
    #2;
    sys_rst = 1'b0;
    t_sizes();
    t_update();
    t_faults();
    t_invalid();
    final_report();
  end
endmodule
